// File: feac_codeword_controller.sv
// FEAC codeword transmitter, receiver and receive FIFO behind AHB-Lite.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module feac_codeword_controller
   import feac_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   input  wire logic        line_clk,
   input  wire logic        rx_feac,
   output var  logic        tx_feac
);

   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

   logic            acc;
   logic            ph_rd_r;
   logic            ph_wr_r;
   logic [7:0]      ph_addr_r;
   logic            ctrl_wr;
   logic            pop_req;
   logic            pop;
   tx_mode_t        mode_r;
   logic [5:0]      tx_first_code;
   logic [5:0]      tx_second_code;
   logic            tx_restart_r;
   logic [1:0]      lclk_sync_r;
   logic            lclk_prev_r;
   logic [1:0]      rx_sync_r;
   logic            bit_en;
   logic            rx_bit;
   tx_state_t       tx_state_r;
   logic [3:0]      tx_bit_r;
   logic [3:0]      tx_rep_r;
   logic            tx_dual_r;
   logic [5:0]      cur_code;
   logic [15:0]     cur_word;
   logic [3:0]      tx_idx;
   logic [15:0]     rx_sh_r;
   logic [15:0]     rx_new;
   logic            match;
   logic [5:0]      code_w;
   logic [4:0]      since_r;
   logic [5:0]      cand_r;
   logic [1:0]      cand_cnt_r;
   logic            hit3;
   logic            det_r;
   logic [5:0]      det_code_r;
   logic [1:0]      diff_r;
   logic [4:0]      ones_r;
   logic            idle_set;
   logic            idle_r;
   logic            push_req;
   logic            push_ok;
   logic            overflow_r;
   logic [AW-1:0]   wr_ptr_r;
   logic [AW-1:0]   rd_ptr_r;
   logic [CW-1:0]   count_r;
   logic [5:0]      head;
   status_t         stat;

   // ==========================================================================
   // AHB-Lite slave: reads take one wait state so read data leave a flop
   // ==========================================================================
   assign acc     = hsel && htrans[1] && hready;
   assign ctrl_wr = ph_wr_r && (ph_addr_r == CTRL_OFF);
   assign pop_req = ph_rd_r && (ph_addr_r == FIFO_OFF);
   assign pop     = pop_req && (count_r != '0);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ph_rd_r   <= 1'b0;
         ph_wr_r   <= 1'b0;
         ph_addr_r <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         ph_rd_r   <= acc && !hwrite;
         ph_wr_r   <= acc && hwrite;
         hreadyout <= !(acc && !hwrite);
         hresp     <= 1'b0;
         if (acc)
         begin
            ph_addr_r <= haddr[7:0];
         end
      end
   end

   assign stat = '{tx_busy:  (tx_state_r != TX_IDLE) || tx_restart_r,
                   overflow: overflow_r,
                   idle:     idle_r,
                   detected: det_r,
                   empty:    (count_r == '0)};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (ph_rd_r)
      begin
         hrdata <= 32'h0000_0000;
         unique case (ph_addr_r)
            CTRL_OFF:   hrdata[MODE_LSB +: 2] <= mode_r;
            CODES_OFF:
            begin
               hrdata[FIRST_LSB +: CODE_W]  <= tx_first_code;
               hrdata[SECOND_LSB +: CODE_W] <= tx_second_code;
            end
            STATUS_OFF:
            begin
               hrdata[4:0]            <= stat;
               hrdata[FILL_LSB +: CW] <= count_r;
            end
            FIFO_OFF:
            begin
               if (pop)
               begin
                  hrdata[CODE_W-1:0] <= head;
                  hrdata[VALID_BIT]  <= 1'b1;
               end
            end
            default:    hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================================
   // Software-written registers
   // ==========================================================================
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mode_r         <= MODE_IDLE;
         tx_first_code  <= CODE_RST;
         tx_second_code <= CODE_RST;
      end
      else if (ph_wr_r)
      begin
         if (ph_addr_r == CTRL_OFF)
         begin
            mode_r <= tx_mode_t'(hwdata[MODE_LSB +: 2]);
         end
         if (ph_addr_r == CODES_OFF)
         begin
            tx_first_code  <= hwdata[FIRST_LSB +: CODE_W];
            tx_second_code <= hwdata[SECOND_LSB +: CODE_W];
         end
      end
   end

   // A new mode takes effect at the next line bit; the write wins a tie.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_restart_r <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         tx_restart_r <= 1'b1;
      end
      else if (bit_en)
      begin
         tx_restart_r <= 1'b0;
      end
   end

   // ==========================================================================
   // Line pins: two-flop synchronisers and line clock edge detect
   // ==========================================================================
   // The line clock is only sampled, so a stopped line clock simply yields
   // no bit enables and the register side keeps working untouched.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lclk_sync_r <= 2'h0;
         lclk_prev_r <= 1'b0;
         rx_sync_r   <= 2'h3;
      end
      else
      begin
         lclk_sync_r <= {lclk_sync_r[0], line_clk};
         lclk_prev_r <= lclk_sync_r[1];
         rx_sync_r   <= {rx_sync_r[0], rx_feac};
      end
   end

   assign bit_en = lclk_sync_r[1] && !lclk_prev_r;
   assign rx_bit = rx_sync_r[1];

   // ==========================================================================
   // Transmit codeword sequencer
   // ==========================================================================
   // Codes are read live, so rewriting them mid-sequence alters the next bits.
   assign cur_code = (tx_state_r == TX_SECOND) ? tx_second_code : tx_first_code;
   assign cur_word = {1'b0, cur_code[0], cur_code[1], cur_code[2], cur_code[3],
                      cur_code[4], cur_code[5], 1'b0, 8'hff};
   assign tx_idx   = 4'hf - tx_bit_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_state_r <= TX_IDLE;
         tx_bit_r   <= 4'h0;
         tx_rep_r   <= 4'h0;
         tx_dual_r  <= 1'b0;
         tx_feac    <= 1'b1;
      end
      else if (bit_en)
      begin
         if (tx_restart_r)
         begin
            tx_bit_r  <= 4'h0;
            tx_rep_r  <= 4'h0;
            tx_dual_r <= (mode_r == MODE_DUAL);
            tx_feac   <= 1'b1;
            unique case (mode_r)
               MODE_IDLE:   tx_state_r <= TX_IDLE;
               MODE_SINGLE: tx_state_r <= TX_FIRST;
               MODE_DUAL:   tx_state_r <= TX_FIRST;
               MODE_CONT:   tx_state_r <= TX_CONT;
            endcase
         end
         else if (tx_state_r == TX_IDLE)
         begin
            tx_feac <= 1'b1;
         end
         else
         begin
            tx_feac  <= cur_word[tx_idx];
            tx_bit_r <= tx_bit_r + 4'h1;
            if ((tx_bit_r == 4'hf) && (tx_state_r != TX_CONT))
            begin
               if (tx_rep_r == TX_REPEAT - 4'h1)
               begin
                  tx_rep_r <= 4'h0;
                  if ((tx_state_r == TX_FIRST) && tx_dual_r)
                  begin
                     tx_state_r <= TX_SECOND;
                  end
                  else
                  begin
                     tx_state_r <= TX_IDLE;
                  end
               end
               else
               begin
                  tx_rep_r <= tx_rep_r + 4'h1;
               end
            end
         end
      end
   end

   // ==========================================================================
   // Receive boundary search, validation and idle detection
   // ==========================================================================
   assign rx_new   = {rx_sh_r[14:0], rx_bit};
   assign match    = bit_en && !rx_new[15] && !rx_new[8]
                     && (rx_new[7:0] == 8'hff);
   assign code_w   = {rx_new[9], rx_new[10], rx_new[11], rx_new[12],
                      rx_new[13], rx_new[14]};
   assign hit3     = match && (since_r == WORD_GAP) && (code_w == cand_r)
                     && (cand_cnt_r == VALID_COUNT - 2'h1);
   assign push_req = hit3 && !(det_r && (det_code_r == code_w));
   assign idle_set = bit_en && rx_bit && (ones_r == IDLE_ONES - 5'h1);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rx_sh_r    <= 16'hffff;
         since_r    <= IDLE_ONES;
         cand_r     <= CODE_RST;
         cand_cnt_r <= 2'h0;
         ones_r     <= 5'h00;
      end
      else if (bit_en)
      begin
         rx_sh_r <= rx_new;
         ones_r  <= !rx_bit ? 5'h00 :
                    (ones_r == IDLE_ONES) ? IDLE_ONES : ones_r + 5'h1;
         if (match)
         begin
            since_r <= 5'h00;
            cand_r  <= code_w;
            if ((since_r == WORD_GAP) && (code_w == cand_r))
            begin
               cand_cnt_r <= (cand_cnt_r == VALID_COUNT) ? VALID_COUNT
                             : cand_cnt_r + 2'h1;
            end
            else
            begin
               cand_cnt_r <= 2'h1;
            end
         end
         else
         begin
            if (since_r != IDLE_ONES)
            begin
               since_r <= since_r + 5'h1;
            end
            if (since_r >= WORD_GAP)
            begin
               cand_cnt_r <= 2'h0;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         det_r      <= 1'b0;
         det_code_r <= CODE_RST;
         diff_r     <= 2'h0;
         idle_r     <= 1'b0;
      end
      else
      begin
         if (hit3)
         begin
            det_r      <= 1'b1;
            det_code_r <= code_w;
            diff_r     <= 2'h0;
         end
         else if (idle_set)
         begin
            det_r <= 1'b0;
         end
         else if (match && det_r)
         begin
            if (code_w == det_code_r)
            begin
               diff_r <= 2'h0;
            end
            else if (diff_r == DIFF_COUNT - 2'h1)
            begin
               det_r  <= 1'b0;
               diff_r <= 2'h0;
            end
            else
            begin
               diff_r <= diff_r + 2'h1;
            end
         end
         if (hit3)
         begin
            idle_r <= 1'b0;
         end
         else if (idle_set)
         begin
            idle_r <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Receive FIFO control
   // ==========================================================================
   assign push_ok = push_req && (count_r != FULL_CNT);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push_ok)
         begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         count_r <= count_r + CW'(push_ok) - CW'(pop);
      end
   end

   // Overflow is sticky; writing one clears it, but a new drop wins the tie.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         overflow_r <= 1'b0;
      end
      else if (push_req && (count_r == FULL_CNT))
      begin
         overflow_r <= 1'b1;
      end
      else if (ph_wr_r && (ph_addr_r == STATUS_OFF) && hwdata[OVF_BIT])
      begin
         overflow_r <= 1'b0;
      end
   end

   feac_fifo_mem #(
      .WIDTH (CODE_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk   (clk),
      .we    (push_ok),
      .waddr (wr_ptr_r),
      .wdata (code_w),
      .raddr (rd_ptr_r),
      .rdata (head)
   );

   // ==========================================================================
   // Assertions
   // ==========================================================================
   tx_idle_ones_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      bit_en && !tx_restart_r && (tx_state_r == TX_IDLE) |=> tx_feac)
      else $error("Idle transmitter sent a zero.");

   tx_single_end_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      bit_en && !tx_restart_r && (tx_state_r == TX_FIRST) && !tx_dual_r
      && (tx_rep_r == 4'h9) && (tx_bit_r == 4'hf) |=> (tx_state_r == TX_IDLE))
      else $error("Single mode did not stop after ten codewords.");

   tx_dual_next_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      bit_en && !tx_restart_r && (tx_state_r == TX_FIRST) && tx_dual_r
      && (tx_rep_r == 4'h9) && (tx_bit_r == 4'hf) |=> (tx_state_r == TX_SECOND))
      else $error("Dual mode did not move to the second code.");

   tx_cont_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (tx_state_r == TX_CONT) && !tx_restart_r |=> (tx_state_r == TX_CONT))
      else $error("Continuous mode ended without a mode write.");

   tx_first_bit_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      bit_en && !tx_restart_r && (tx_state_r != TX_IDLE) && (tx_bit_r == 4'h1)
      |=> (tx_feac == $past(cur_code[0])))
      else $error("First code bit was not bit 0.");

   tx_frame_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      bit_en && !tx_restart_r && (tx_state_r != TX_IDLE)
      && ((tx_bit_r == 4'h0) || (tx_bit_r == 4'h7)) |=> !tx_feac)
      else $error("Codeword framing zero missing.");

   rx_idle_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      idle_set && !hit3 |=> idle_r && !det_r)
      else $error("Sixteen ones did not declare idle.");

   fifo_push_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      push_ok && !pop |=> (count_r == $past(count_r) + CW'(1)))
      else $error("Validated code was not queued.");

   fifo_drop_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      push_req && (count_r == FULL_CNT) |=> overflow_r && $stable(wr_ptr_r))
      else $error("Push while full was not dropped.");

   fifo_empty_rd_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      pop_req && (count_r == '0) && !push_ok
      |=> $stable(rd_ptr_r) && (count_r == '0))
      else $error("Read of empty FIFO changed state.");

endmodule // feac_codeword_controller

`default_nettype wire

// File: feac_pkg.sv
// Shared constants and types for the FEAC codeword controller.
package feac_pkg;

   // ==========================================================================
   // Register map (byte addresses, one aligned word each)
   // ==========================================================================
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] CODES_OFF  = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] FIFO_OFF   = 8'h0c;

   // ==========================================================================
   // Field positions and reset values
   // ==========================================================================
   localparam int         MODE_LSB       = 0;
   localparam int         FIRST_LSB      = 0;
   localparam int         SECOND_LSB     = 8;
   localparam int         OVF_BIT        = 3;
   localparam int         FILL_LSB       = 8;
   localparam int         VALID_BIT      = 8;
   localparam logic [5:0] CODE_RST       = 6'h00;
   localparam int         CODE_W         = 6;
   localparam int         FIFO_DEPTH_DEF = 4;

   // ==========================================================================
   // Line timing counts, in codewords (TX_REPEAT, VALID_COUNT, DIFF_COUNT) or line bits
   // ==========================================================================
   localparam logic [3:0] TX_REPEAT   = 4'ha;
   localparam logic [1:0] VALID_COUNT = 2'h3;
   localparam logic [1:0] DIFF_COUNT  = 2'h2;
   localparam logic [4:0] IDLE_ONES   = 5'h10;
   localparam logic [4:0] WORD_GAP    = 5'h0f;

   // ==========================================================================
   // Modes, states and carriers
   // ==========================================================================
   typedef enum logic [1:0] {
      MODE_IDLE   = 2'h0,
      MODE_SINGLE = 2'h1,
      MODE_DUAL   = 2'h2,
      MODE_CONT   = 2'h3
   } tx_mode_t;

   typedef enum logic [1:0] {
      TX_IDLE   = 2'h0,
      TX_FIRST  = 2'h1,
      TX_SECOND = 2'h3,
      TX_CONT   = 2'h2
   } tx_state_t;

   typedef struct packed {
      logic tx_busy;
      logic overflow;
      logic idle;
      logic detected;
      logic empty;
   } status_t;

endpackage

// File: feac_fifo_mem.sv
// Small code memory for the receive FIFO with a registered read port.
`timescale 1ns/1ps
`default_nettype none

module feac_fifo_mem
#(
   parameter int WIDTH = 6,
   parameter int DEPTH = 4,
   parameter int AW    = 2
)
(
   input  wire logic             clk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output var  logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================================================
   // Storage
   // ==========================================================================
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // Forwarding keeps the head word valid in the same cycle the fill rises.
   always_ff @(posedge clk)
   begin
      if (we && (waddr == raddr))
      begin
         rdata <= wdata;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end

endmodule // feac_fifo_mem

`default_nettype wire

// File: feac_line_model.sv
// Line-side model: free-running line clock, receive stream, transmit capture.
`timescale 1ns/1ps
`default_nettype none

module feac_line_model
(
   output var  logic line_clk,
   output var  logic rx_feac,
   input  wire logic tx_feac
);
   logic tx_q [$];
   logic rx_q [$];
   logic stop = 1'b0;

   // ==========================================================================
   // Line clock and bit streams
   // ==========================================================================
   // The overhead stream is continuous; the clock halts only when a test
   // asks for it, to show that the register side needs no line clock.
   // Bits move mid-bit, well away from the edge the block samples on.
   initial
   begin
      line_clk = 1'b0;
      rx_feac  = 1'b1;
      forever
      begin
         #80;
         if (!stop)
         begin
            line_clk = ~line_clk;
            if (!line_clk)
            begin
               tx_q.push_back(tx_feac);
               if (rx_q.size() > 0)
                  rx_feac = rx_q.pop_front();
               else
                  rx_feac = 1'b1;
            end
         end
      end
   end

   // Halts or restarts the line clock at its present level.
   task automatic hold(input logic h);
      stop = h;
   endtask

   // Queues n codewords and returns once the last bit is on the line.
   task automatic send_word(input logic [5:0] c, input int n);
      for (int i = 0; i < n; i++)
      begin
         rx_q.push_back(1'b0);
         for (int k = 0; k < 6; k++)
            rx_q.push_back(c[k]);
         rx_q.push_back(1'b0);
         repeat (8) rx_q.push_back(1'b1);
      end
      wait (rx_q.size() == 0);
   endtask
endmodule // feac_line_model

`default_nettype wire

// File: test_feac_codeword_controller.sv
// Self-checking testbench for the FEAC codeword controller.
`timescale 1ns/1ps
`default_nettype none

module test_feac_codeword_controller
   import feac_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        line_clk;
   logic        rx_feac;
   logic        tx_feac;
   logic [31:0] rd;
   logic [5:0]  rx_codes [5];
   int          miscompares;
   int          comparisons;

   feac_codeword_controller feac_codeword_controller_i
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .line_clk  (line_clk),
      .rx_feac   (rx_feac),
      .tx_feac   (tx_feac)
   );

   feac_line_model line_i
   (
      .line_clk (line_clk),
      .rx_feac  (rx_feac),
      .tx_feac  (tx_feac)
   );

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One single transfer; the master waits as long as the slave asks.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   // Idle checks skip three bits, since a codeword may still be ending.
   task automatic chk_tx(input int na, input int nb);
      int   s;
      int   w;
      int   k;
      logic e;
      s = (na == 0) ? 3 : 0;
      while (na > 0 && s < line_i.tx_q.size() && line_i.tx_q[s] !== 1'b0)
         s++;
      chk("tx lead ones", 32'h1, {31'h0, s <= 3});
      for (int i = s; i < line_i.tx_q.size(); i++)
      begin
         w = (i - s) / 16;
         k = (i - s) % 16;
         e = (w >= na + nb) || (k > 7) ||
             (k > 0 && k < 7 && (w < na ? 6'h0b >> (k - 1) :
                                          6'h34 >> (k - 1)) & 6'h01);
         chk("tx_feac bit", {31'h0, e}, {31'h0, line_i.tx_q[i]});
      end
   endtask

   task automatic run_tx(input logic [1:0] m, input int na, input int nb,
                         input int bits);
      bus(1'b1, CTRL_OFF, {30'h0, m});
      @(posedge line_clk);
      line_i.tx_q.delete();
      repeat (bits) @(posedge line_clk);
      chk_tx(na, nb);
   endtask

   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================================
   // Clock, watchdog and test sequence
   // ==========================================================================
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      complete_run();
   end

   initial
   begin
      hsel        = 1'b0;
      haddr       = 32'h0;
      htrans      = 2'h0;
      hwrite      = 1'b0;
      hsize       = 3'h0;
      hwdata      = 32'h0;
      rst_n       = 1'b0;
      miscompares = 0;
      comparisons = 0;
      rx_codes    = '{6'h05, 6'h12, 6'h24, 6'h09, 6'h30};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(STATUS_OFF, 32'h1, "status after reset");
      rdchk(FIFO_OFF, 32'h0, "empty fifo read");
      rdchk(8'h10, 32'h0, "unmapped read");
      bus(1'b1, CODES_OFF, 32'hffff_ffff);
      rdchk(CODES_OFF, 32'h3f3f, "code fields");
      bus(1'b1, CODES_OFF, 32'h340b);
      run_tx(MODE_SINGLE, 10, 0, 180);
      run_tx(MODE_DUAL, 10, 10, 340);
      run_tx(MODE_CONT, 1000, 0, 100);
      rdchk(CTRL_OFF, {30'h0, MODE_CONT}, "mode field");
      rdchk(STATUS_OFF, 32'h15, "status busy");
      run_tx(MODE_IDLE, 0, 0, 40);
      rdchk(STATUS_OFF, 32'h5, "status idle");
      line_i.send_word(rx_codes[0], 3);
      repeat (30) @(posedge clk);
      rdchk(STATUS_OFF, 32'h102, "status detect");
      line_i.send_word(rx_codes[1], 2);
      repeat (30) @(posedge clk);
      rdchk(STATUS_OFF, 32'h100, "status cleared");
      for (int i = 1; i < 5; i++)
      begin
         repeat (40) @(posedge line_clk);
         line_i.send_word(rx_codes[i], 3);
      end
      repeat (40) @(posedge line_clk);
      rdchk(STATUS_OFF, 32'h40c, "status overflow");
      line_i.hold(1'b1);
      for (int i = 0; i < 4; i++)
         rdchk(FIFO_OFF, {23'h0, 1'b1, 2'h0, rx_codes[i]}, "fifo code");
      rdchk(FIFO_OFF, 32'h0, "empty read");
      rdchk(STATUS_OFF, 32'hd, "status drained");
      bus(1'b1, STATUS_OFF, 32'h8);
      rdchk(STATUS_OFF, 32'h5, "overflow cleared");
      complete_run();
   end
endmodule // test_feac_codeword_controller

`default_nettype wire
